// ### design/setpoint_host.sv
// host end: bit-bangs a 12-bit set-point word onto the link
`default_nettype none
module setpoint_host (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  setpoint_if.host                             link,
  input  wire logic                            send,
  input  wire logic [setpoint_pkg::WORD_W-1:0] word,
  output logic                                 busy,
  output logic                                 fault
);
  import setpoint_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_PREP = 3'b001, S_LOW = 3'b011, S_HIGH = 3'b010,
    S_SEL = 3'b110, S_XLOW = 3'b111, S_XHIGH = 3'b101
  } phase_t;

  typedef struct packed {
    phase_t            phase;
    logic [WORD_W-1:0] data;
    logic [3:0]        bits;
    logic [CNT_W-1:0]  cnt;
    logic              sdo, sck, sel_n, xfer_n, busy;
    logic [1:0]        flt_sync;
    logic              fault;
  } host_state_t;
  host_state_t s, next_s;

  always_comb begin
    next_s          = s;
    next_s.flt_sync = {s.flt_sync[0], ~link.fault_n};
    next_s.fault    = s.flt_sync[1];
    if (s.cnt != '0) begin
      next_s.cnt = s.cnt - 12'h001;
    end else begin
      unique case (s.phase)
        S_IDLE: if (send) begin
          next_s.data  = word;
          next_s.busy  = 1'b1;
          next_s.phase = S_PREP;
          next_s.cnt   = 12'(PREP_CYCLES);
        end
        S_PREP: begin
          next_s.sel_n = 1'b0;
          next_s.sdo   = s.data[MSB_IDX];
          next_s.data  = {s.data[WORD_W-2:0], 1'b0};
          next_s.bits  = 4'h0;
          next_s.phase = S_LOW;
          next_s.cnt   = 12'(HALF_CYCLES);
        end
        S_LOW: begin
          next_s.sck = 1'b0;
          // next bit moves on the falling edge, never with the capturing rise
          if (s.bits != 4'h0) begin
            next_s.sdo  = s.data[MSB_IDX];
            next_s.data = {s.data[WORD_W-2:0], 1'b0};
          end
          next_s.phase = S_HIGH;
          next_s.cnt   = 12'(HALF_CYCLES);
        end
        S_HIGH: begin
          next_s.sck = 1'b1;
          next_s.cnt = 12'(HALF_CYCLES);
          if (s.bits == LAST_BIT) begin
            next_s.phase = S_SEL;
          end else begin
            next_s.bits  = s.bits + 4'h1;
            next_s.phase = S_LOW;
          end
        end
        S_SEL: begin
          next_s.sel_n = 1'b1;
          next_s.phase = S_XLOW;
          next_s.cnt   = 12'(HALF_CYCLES);
        end
        S_XLOW: begin
          next_s.xfer_n = 1'b0;
          next_s.phase  = S_XHIGH;
          next_s.cnt    = 12'(HALF_CYCLES);
        end
        S_XHIGH: begin
          next_s.xfer_n = 1'b1;
          next_s.busy   = 1'b0;
          next_s.phase  = S_IDLE;
          next_s.cnt    = 12'(PREP_CYCLES);
        end
        default: next_s.phase = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '{phase: S_IDLE, data: '0, bits: '0, cnt: '0, sdo: 1'b0, sck: 1'b1,
             sel_n: 1'b1, xfer_n: 1'b1, busy: 1'b0, flt_sync: '0, fault: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign link.serial_in        = s.sdo;
  assign link.shift_clk        = s.sck;
  assign link.select_n         = s.sel_n;
  assign link.transfer_pulse_n = s.xfer_n;
  assign busy                  = s.busy;
  assign fault                 = s.fault;
endmodule
`default_nettype wire

// ### design/setpoint_pkg.sv
// shared constants for the serial load-current set-point link
`default_nettype none
package setpoint_pkg;
  localparam int unsigned WORD_W          = 12;
  localparam int unsigned WORD_STEPS      = 4096;
  localparam int unsigned MSB_IDX         = 11;
  localparam int unsigned BIT_CNT_W       = 4;
  localparam logic [3:0]  LAST_BIT        = 4'hB;
  localparam logic [11:0] SETPOINT_RESET  = 12'h000;
  localparam int unsigned REF_CLK_HZ      = 25_000_000;
  localparam int unsigned PREP_TIME_NS    = 1000;
  localparam int unsigned PREP_CYCLES     = (PREP_TIME_NS * (REF_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SHIFT_MAX_HZ    = 500_000;
  localparam int unsigned HALF_CYCLES     = (REF_CLK_HZ / SHIFT_MAX_HZ + 1) / 2;
  localparam int unsigned SETTLE_TIME_US  = 100;
  localparam int unsigned SETTLE_CYCLES   = SETTLE_TIME_US * (REF_CLK_HZ / 1_000_000);
  localparam int unsigned CNT_W           = 12;
  localparam real         FULL_SCALE_AMPS = 10.0;
  localparam real         MAX_CODE_AMPS   = 9.99756;
  localparam real         FAULT_VOLTS     = 2.5;
  localparam logic [11:0] FAULT_MV        = 12'h9C4;
endpackage
`default_nettype wire

// ### design/setpoint_if.sv
// interface joining host and load ends of the set-point link
`default_nettype none
interface setpoint_if;
  logic serial_in;
  logic shift_clk;
  logic select_n;
  logic transfer_pulse_n;
  logic fault_n;
  modport host (output serial_in, output shift_clk, output select_n,
                output transfer_pulse_n, input fault_n);
  modport load (input serial_in, input shift_clk, input select_n,
                input transfer_pulse_n, output fault_n);
endinterface
`default_nettype wire

// ### design/setpoint_load.sv
// load end: shifts the set-point word in on the link clock and applies it
// Functional notes
// - word is straight binary, zero means zero
// - one code step is full scale over 4096
// - host idles all strobes high for 1 us
// - bits arrive and assemble MSB first
// - data captured on rising shift clock
// - host pulses clock high-low-high per bit
// - twelve rising edges, clock at most 500 kHz
// - select high then transfer pulse copies word
// - new current settles about 100 us later
// - fault when load voltage under 2.5 V
// - fault output low while undervoltage persists
`default_nettype none
module setpoint_load (
  input  wire logic                           ref_clk,
  input  wire logic                           rst_n,
  setpoint_if.load                            link,
  input  wire logic [11:0]                    load_mv,
  output logic      [setpoint_pkg::WORD_W-1:0] setpoint,
  output logic                                setpoint_settled,
  output logic                                word_complete
);
  import setpoint_pkg::*;

  // link-clock domain: input register, shifted only while select is low
  typedef struct packed {
    logic [WORD_W-1:0] shift;
  } link_state_t;
  link_state_t l, next_l;
  logic xfer_seen;

  always_comb begin
    next_l = l;
    if (!link.select_n) begin
      next_l.shift = {l.shift[WORD_W-2:0], link.serial_in};
    end
  end

  always_ff @(posedge link.shift_clk or negedge rst_n) begin
    if (!rst_n) begin
      l <= '{shift: SETPOINT_RESET};
    end else begin
      l <= next_l;
    end
  end

  // reference-clock domain
  typedef struct packed {
    logic [1:0]        sel_sync;
    logic [2:0]        xfer_sync;
    logic [WORD_W-1:0] conv_hold;
    logic [WORD_W-1:0] setpoint;
    logic [12:0]       settle;
    logic              settled;
    logic              complete;
    logic [1:0]        uv_sync;
    logic              fault_n;
  } ref_state_t;
  ref_state_t r, next_r;

  always_comb begin
    next_r           = r;
    next_r.sel_sync  = {r.sel_sync[0], link.select_n};
    next_r.xfer_sync = {r.xfer_sync[1:0], link.transfer_pulse_n};
    next_r.complete  = 1'b0;
    // rising transfer edge with select high; the input register is quiet
    // then, since it only shifts while select is low
    xfer_seen = r.sel_sync[1] && r.xfer_sync[1] && !r.xfer_sync[2];
    if (xfer_seen) begin
      next_r.conv_hold = l.shift;
      next_r.complete  = 1'b1;
      next_r.settle    = 13'(SETTLE_CYCLES);
      next_r.settled   = 1'b0;
    end else if (r.settle != 13'h0000) begin
      next_r.settle = r.settle - 13'h0001;
      if (r.settle == 13'h0001) begin
        next_r.setpoint = r.conv_hold;
        next_r.settled  = 1'b1;
      end
    end
    next_r.uv_sync = {r.uv_sync[0], load_mv < FAULT_MV};
    next_r.fault_n = ~r.uv_sync[1];
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '{sel_sync: 2'h3, xfer_sync: 3'h7, conv_hold: SETPOINT_RESET,
             setpoint: SETPOINT_RESET,
             settle: '0, settled: 1'b1, complete: 1'b0, uv_sync: '0, fault_n: 1'b1};
    end else begin
      r <= next_r;
    end
  end

  assign link.fault_n     = r.fault_n;
  assign setpoint         = r.setpoint;
  assign setpoint_settled = r.settled;
  assign word_complete    = r.complete;
endmodule
`default_nettype wire

// ### testbench/setpoint_assertions.sv
// concurrent checks on the set-point link wires
`default_nettype none
module setpoint_assertions
  import setpoint_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic serial_in,
  input wire logic shift_clk,
  input wire logic select_n,
  input wire logic transfer_pulse_n,
  input wire logic fault_n,
  input wire logic [11:0] load_mv
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned idle_cnt;
  int unsigned low_cnt;
  logic [4:0]  bit_cnt;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= 0;
      low_cnt <= 0;
      bit_cnt <= 5'h00;
    end else begin
      idle_cnt <= (select_n && transfer_pulse_n && shift_clk) ? idle_cnt + 1 : 0;
      low_cnt <= shift_clk ? 0 : low_cnt + 1;
      if ($fell(select_n)) bit_cnt <= 5'h00;
      else if ($rose(shift_clk) && !select_n) bit_cnt <= bit_cnt + 5'h01;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence xfer_low_s; $fell(transfer_pulse_n) && shift_clk && select_n; endsequence
  sequence xfer_end_s; $rose(transfer_pulse_n) && shift_clk && select_n; endsequence
  a_prep_idle: assert property ($fell(select_n) |-> idle_cnt >= PREP_CYCLES)
    else $error("select fell before idle time");
  a_sck_rate: assert property ($rose(shift_clk) |-> low_cnt >= HALF_CYCLES)
    else $error("shift clock too fast");
  a_data_hold: assert property ($rose(shift_clk) && !select_n |-> $stable(serial_in))
    else $error("data moved at clock edge");
  a_word_len: assert property ($rose(select_n) |-> bit_cnt == 5'h0C)
    else $error("word not twelve bits");
  a_select_first: assert property ($fell(transfer_pulse_n) |-> select_n)
    else $error("transfer with select low");
  a_xfer_pulse: assert property (xfer_low_s |-> ##[20:30] xfer_end_s)
    else $error("transfer pulse malformed");
  a_sck_gated: assert property ($fell(shift_clk) |-> !select_n && transfer_pulse_n)
    else $error("clock toggled outside frame");
  a_fault_low: assert property (load_mv < FAULT_MV |-> ##3 !fault_n)
    else $error("undervoltage not flagged");
  a_fault_high: assert property (load_mv >= FAULT_MV |-> ##3 fault_n)
    else $error("fault flagged without undervoltage");
  a_sck_idle: assert property ($fell(select_n) |-> shift_clk && transfer_pulse_n)
    else $error("clock not idle high at start");
endmodule
`default_nettype wire

// ### testbench/serial_load_current_setpoint_tb.sv
// self-checking bench joining host and load ends
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %s exp %h got %h", nm, e, g); end end
module serial_load_current_setpoint_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import setpoint_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        send = 1'b0;
  logic [11:0] word = 12'h000;
  logic [11:0] load_mv = 12'hFFF;
  logic [11:0] setpoint;
  logic [11:0] seen;
  logic        busy;
  logic        fault;
  logic        settled;
  logic        done;
  int          err_total = 0;
  int          cmp_count = 0;
  int          cycles = 0;
  setpoint_if u_setpoint_if ();
  setpoint_host u_setpoint_host (.ref_clk(ref_clk), .rst_n(rst_n), .link(u_setpoint_if),
    .send(send), .word(word), .busy(busy), .fault(fault));
  setpoint_load u_setpoint_load (.ref_clk(ref_clk), .rst_n(rst_n), .link(u_setpoint_if),
    .load_mv(load_mv), .setpoint(setpoint), .setpoint_settled(settled), .word_complete(done));
  setpoint_assertions u_setpoint_assertions (.ref_clk(ref_clk), .rst_n(rst_n),
    .serial_in(u_setpoint_if.serial_in), .shift_clk(u_setpoint_if.shift_clk),
    .select_n(u_setpoint_if.select_n), .transfer_pulse_n(u_setpoint_if.transfer_pulse_n),
    .fault_n(u_setpoint_if.fault_n), .load_mv(load_mv));
  always #20 ref_clk = ~ref_clk;
  always @(posedge u_setpoint_if.shift_clk) begin
    if (!u_setpoint_if.select_n) seen <= {seen[10:0], u_setpoint_if.serial_in};
  end
  task automatic summarize();
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      summarize();
    end
  end
  task automatic send_word(input logic [11:0] w);
    logic [11:0] old;
    int n;
    old = setpoint;
    n = 0;
    @(posedge ref_clk);
    send <= 1'b1;
    word <= w;
    while (busy !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    send <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      `CHK("held setpoint", old, setpoint)
      n++;
    end
    `CHK("word done", 1'b1, done)
    `CHK("busy after transfer", 1'b0, busy)
    `CHK("wire word", w, seen)
    @(negedge ref_clk);
    `CHK("settled low", 1'b0, settled)
    n = 1;
    while (settled !== 1'b1 && n < 3000) begin
      @(negedge ref_clk);
      n++;
    end
    `CHK("settle time", 1'b1, n >= SETTLE_CYCLES - 10 && n <= SETTLE_CYCLES)
    `CHK("setpoint", w, setpoint)
  endtask
  task automatic fault_case(input logic [11:0] mv, input logic exp_n);
    @(posedge ref_clk);
    load_mv <= mv;
    repeat (8) @(negedge ref_clk);
    `CHK("fault_n", exp_n, u_setpoint_if.fault_n)
    `CHK("host fault", ~exp_n, fault)
  endtask
  logic [11:0] codes [5] = '{12'hFFF, 12'hC00, 12'h7FF, 12'h001, 12'h000};
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(negedge ref_clk);
    `CHK("reset setpoint", SETPOINT_RESET, setpoint)
    fault_case(12'h9C3, 1'b0);
    fault_case(12'h9C4, 1'b1);
    fault_case(12'hFFF, 1'b1);
    for (int i = 0; i < 5; i++) begin
      send_word(codes[i]);
    end
    summarize();
  end
endmodule
`default_nettype wire
